// ===== rtl/tcpwm_pkg.sv
// Purpose: Shared constants and carriers of the three channel PWM timer unit
// Assumes: 16-bit register port, word indexed addresses
// Notes:   Register offsets are word indices on the plain register port
package tcpwm_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int MAIN_W = 16;
    localparam int AUX_W  = 10;
    localparam int NCH    = 3;
    localparam int PRE_W  = 7;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_TIMER_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_MAIN_PERIOD  = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_AUX_PERIOD   = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_DEAD_TIME    = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_COMPARE0     = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_COMPARE1     = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_COMPARE2     = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_AUX_COMPARE  = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_PASSIVE_CTRL = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_MODE_SELECT  = 4'h9;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_EDGE = 4'ha;
    localparam logic [ADDR_W-1:0] OFF_MAIN_COUNT   = 4'hb;
    localparam logic [ADDR_W-1:0] OFF_AUX_COUNT    = 4'hc;
    localparam logic [ADDR_W-1:0] OFF_STATUS       = 4'hd;

    // timer_ctrl field positions
    localparam int CTRL_MAIN_PRE = 0;
    localparam int CTRL_MAIN_RUN = 3;
    localparam int CTRL_CENTER   = 4;
    localparam int CTRL_AUX_PRE  = 5;
    localparam int CTRL_AUX_RUN  = 8;
    localparam int CTRL_AUX_OE   = 9;
    localparam int CTRL_AUX_INV  = 10;
    localparam int CTRL_TRAP_EN  = 11;

    // channel_mode_select: four bits per channel
    localparam int MODE_FIELD_W = 4;
    localparam int MODE_PIN_LO  = 0;
    localparam int MODE_CAPTURE = 2;
    localparam int MODE_BURST   = 3;

    // pin_select_field bits; both set routes to both pins
    localparam int PIN_PRIMARY = 0;
    localparam int PIN_COMPL   = 1;

    // capture_edge: two bits per channel
    localparam int EDGE_RISE = 0;
    localparam int EDGE_FALL = 1;

    // passive_level_ctrl bit positions
    localparam int PASS_PRIMARY = 0;
    localparam int PASS_COMPL   = 3;
    localparam int PASS_AUX     = 6;
    localparam int LEVEL_W      = 7;

    // Values after reset
    localparam logic [DATA_W-1:0] RST_CTRL        = 16'h0000;
    localparam logic [DATA_W-1:0] RST_MAIN_PERIOD = 16'hffff;
    localparam logic [DATA_W-1:0] RST_AUX_PERIOD  = 16'h03ff;
    localparam logic [DATA_W-1:0] RST_COMPARE     = 16'hffff;
    localparam logic [DATA_W-1:0] RST_AUX_COMPARE = 16'h03ff;
    localparam logic [DATA_W-1:0] RST_ZERO        = 16'h0000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } tcpwm_bus_t;

    typedef struct packed {
        logic [NCH-1:0] primary_out;
        logic [NCH-1:0] primary_oe;
        logic [NCH-1:0] complementary_out;
        logic           aux_pwm_out;
    } tcpwm_pins_t;

endpackage

// ===== rtl/tcpwm_chan.sv
// Purpose: Compare state of one main timer channel, both output phases
// Assumes: next_count is the count the timer takes on this tick
// Notes:   mark_up is the direction after the step; edge mode holds it high
`timescale 1ns/1ns
module tcpwm_chan #(
    parameter int W = 16
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         tick,
    input  wire logic         clear,
    input  wire logic         mark_up,
    input  wire logic [W-1:0] next_count,
    input  wire logic [W-1:0] offset,
    input  wire logic [W-1:0] compare,
    output logic              prim_act,
    output logic              comp_act
);

    if (W < 2) begin : g_check
        $error("tcpwm_chan: width below two bits");
    end

    typedef struct packed {
        logic prim;
        logic comp;
    } tcpwm_chan_st_t;

    tcpwm_chan_st_t st;
    tcpwm_chan_st_t next_st;
    logic [W:0]     shifted;

    always_comb begin
        next_st = st;
        shifted = {1'b0, next_count} + {1'b0, offset};
        if (tick) begin
            if (clear) begin
                next_st.prim = 1'b0;
                next_st.comp = 1'b0;
            end
            if (next_count == compare) begin
                next_st.prim = mark_up;
            end
            if (shifted == {1'b0, compare}) begin
                next_st.comp = mark_up;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign prim_act = st.prim;
    assign comp_act = st.comp;

endmodule

// ===== rtl/tcpwm_unit.sv
// Purpose: Three channel capture/compare PWM unit with auxiliary channel
// Assumes: Register port strobes one cycle; pins synchronous to clk_sys
// Notes:   Outputs and read data are registered
`timescale 1ns/1ns
module tcpwm_unit #(
    parameter int MAIN_W = tcpwm_pkg::MAIN_W,
    parameter int AUX_W  = tcpwm_pkg::AUX_W
) (
    input  wire logic                               clk_sys,
    input  wire logic                               reset_n,
    input  wire tcpwm_pkg::tcpwm_bus_t              bus,
    output logic [tcpwm_pkg::DATA_W-1:0]            rdata,
    input  wire logic [tcpwm_pkg::NCH-1:0]          cc_pin_in,
    input  wire logic                               emergency_trap,
    input  wire logic [tcpwm_pkg::LEVEL_W-1:0]      port_latch,
    output tcpwm_pkg::tcpwm_pins_t                  pins
);

    if (MAIN_W < 2 || MAIN_W > tcpwm_pkg::DATA_W ||
        AUX_W < 2 || AUX_W > MAIN_W) begin : g_check
        $error("tcpwm_unit: timer widths out of range");
    end

    localparam int NCH = tcpwm_pkg::NCH;
    localparam int DW  = tcpwm_pkg::DATA_W;
    localparam int PW  = tcpwm_pkg::PRE_W;

    typedef struct packed {
        logic [DW-1:0]                   ctrl;
        logic [MAIN_W-1:0]               main_period;
        logic [AUX_W-1:0]                aux_period;
        logic [MAIN_W-1:0]               offset;
        logic [NCH-1:0][MAIN_W-1:0]      compare;
        logic [AUX_W-1:0]                aux_compare;
        logic [tcpwm_pkg::LEVEL_W-1:0]   passive;
        logic [NCH*tcpwm_pkg::MODE_FIELD_W-1:0] mode;
        logic [2*NCH-1:0]                cap_edge;
        logic [PW-1:0]                   pre;
        logic [MAIN_W-1:0]               main_count;
        logic                            main_up;
        logic [AUX_W-1:0]                aux_count;
        logic                            aux_act;
        logic [NCH-1:0]                  cap_prev;
        tcpwm_pkg::tcpwm_pins_t          pins;
        logic [DW-1:0]                   rdata;
    } tcpwm_state_t;

    tcpwm_state_t s;
    tcpwm_state_t next_s;

    logic              main_tick;
    logic              aux_tick;
    logic              center;
    logic [MAIN_W-1:0] main_pv;
    logic [AUX_W-1:0]  aux_pv;
    logic [MAIN_W-1:0] main_next;
    logic              main_dir_next;
    logic              main_wrap;
    logic              main_mark;
    logic [AUX_W-1:0]  aux_next;
    logic              aux_wrap;
    logic [NCH-1:0]    prim_act;
    logic [NCH-1:0]    comp_act;

    function automatic logic [PW-1:0] tcpwm_pre_mask(input logic [2:0] sel);
        logic [PW:0] one_hot;
        one_hot = (PW+1)'(1) << sel;
        return PW'(one_hot - 1'b1);
    endfunction

    // Prescaled ticks from one free divider
    always_comb begin
        main_tick = s.ctrl[tcpwm_pkg::CTRL_MAIN_RUN] &&
            ((s.pre & tcpwm_pre_mask(
                s.ctrl[tcpwm_pkg::CTRL_MAIN_PRE +: 3])) == '0);
        aux_tick = s.ctrl[tcpwm_pkg::CTRL_AUX_RUN] &&
            ((s.pre & tcpwm_pre_mask(
                s.ctrl[tcpwm_pkg::CTRL_AUX_PRE +: 3])) == '0);
        center = s.ctrl[tcpwm_pkg::CTRL_CENTER];
        // Period zero would give one-tick period; floor it
        main_pv = (s.main_period == '0) ? MAIN_W'(1) : s.main_period;
        aux_pv = (s.aux_period == '0) ? AUX_W'(1) : s.aux_period;
    end

    // Main timer stepping
    always_comb begin
        main_next = s.main_count;
        main_dir_next = s.main_up;
        main_wrap = 1'b0;
        if (!center) begin
            main_dir_next = 1'b1;
            if (s.main_count >= main_pv) begin
                main_next = '0;
                main_wrap = 1'b1;
            end else begin
                main_next = s.main_count + 1'b1;
            end
        end else if (s.main_up) begin
            if (s.main_count >= main_pv) begin
                main_next = s.main_count - 1'b1;
                main_dir_next = 1'b0;
            end else begin
                main_next = s.main_count + 1'b1;
                main_dir_next = (main_next != main_pv);
            end
        end else begin
            if (s.main_count == '0) begin
                main_next = MAIN_W'(1);
                main_dir_next = 1'b1;
            end else begin
                main_next = s.main_count - 1'b1;
                main_dir_next = (main_next == '0);
            end
        end
        main_mark = main_dir_next;
    end

    // Auxiliary timer: edge aligned only, no offset
    always_comb begin
        aux_wrap = (s.aux_count >= aux_pv);
        aux_next = aux_wrap ? '0 : s.aux_count + 1'b1;
    end

    for (genvar i = 0; i < NCH; i++) begin : g_chan
        tcpwm_chan #(
            .W (MAIN_W)
        ) u_chan (
            .clk_sys    (clk_sys),
            .reset_n    (reset_n),
            .tick       (main_tick),
            .clear      (main_wrap),
            .mark_up    (main_mark),
            .next_count (main_next),
            .offset     (s.offset),
            .compare    (s.compare[i]),
            .prim_act   (prim_act[i]),
            .comp_act   (comp_act[i])
        );
    end

    always_comb begin
        logic                                 trap;
        logic                                 mod_sig;
        logic [tcpwm_pkg::MODE_FIELD_W-1:0]   fld;
        logic                                 act_p;
        logic                                 act_c;
        logic                                 rise;
        logic                                 fall;
        logic                                 cap_ev;
        logic [DW-1:0]                        rd_val;
        trap = 1'b0;
        mod_sig = 1'b0;
        fld = '0;
        act_p = 1'b0;
        act_c = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        cap_ev = 1'b0;
        rd_val = '0;
        next_s = s;
        next_s.pre = s.pre + 1'b1;
        next_s.cap_prev = cc_pin_in;

        // Timers
        if (main_tick) begin
            next_s.main_count = main_next;
            next_s.main_up = main_dir_next;
        end
        if (aux_tick) begin
            next_s.aux_count = aux_next;
            if (aux_wrap) begin
                next_s.aux_act = 1'b0;
            end
            if (aux_next == s.aux_compare) begin
                next_s.aux_act = 1'b1;
            end
        end

        // Register writes
        if (bus.wr) begin
            unique case (bus.addr)
                tcpwm_pkg::OFF_TIMER_CTRL:
                    next_s.ctrl = bus.wdata;
                tcpwm_pkg::OFF_MAIN_PERIOD:
                    next_s.main_period = bus.wdata[MAIN_W-1:0];
                tcpwm_pkg::OFF_AUX_PERIOD:
                    next_s.aux_period = bus.wdata[AUX_W-1:0];
                tcpwm_pkg::OFF_DEAD_TIME:
                    next_s.offset = bus.wdata[MAIN_W-1:0];
                tcpwm_pkg::OFF_COMPARE0:
                    next_s.compare[0] = bus.wdata[MAIN_W-1:0];
                tcpwm_pkg::OFF_COMPARE1:
                    next_s.compare[1] = bus.wdata[MAIN_W-1:0];
                tcpwm_pkg::OFF_COMPARE2:
                    next_s.compare[2] = bus.wdata[MAIN_W-1:0];
                tcpwm_pkg::OFF_AUX_COMPARE:
                    next_s.aux_compare = bus.wdata[AUX_W-1:0];
                tcpwm_pkg::OFF_PASSIVE_CTRL:
                    next_s.passive = bus.wdata[tcpwm_pkg::LEVEL_W-1:0];
                tcpwm_pkg::OFF_MODE_SELECT:
                    next_s.mode = bus.wdata[NCH*tcpwm_pkg::MODE_FIELD_W-1:0];
                tcpwm_pkg::OFF_CAPTURE_EDGE:
                    next_s.cap_edge = bus.wdata[2*NCH-1:0];
                default: ;
            endcase
        end

        // Capture beats a same-cycle software write
        for (int i = 0; i < NCH; i++) begin
            fld = s.mode[i*tcpwm_pkg::MODE_FIELD_W +: tcpwm_pkg::MODE_FIELD_W];
            rise = cc_pin_in[i] && !s.cap_prev[i];
            fall = !cc_pin_in[i] && s.cap_prev[i];
            cap_ev = fld[tcpwm_pkg::MODE_CAPTURE] &&
                ((rise && s.cap_edge[2*i + tcpwm_pkg::EDGE_RISE]) ||
                 (fall && s.cap_edge[2*i + tcpwm_pkg::EDGE_FALL]));
            if (cap_ev) begin
                next_s.compare[i] = s.main_count;
            end
        end

        // Pin levels, from current state and control
        trap = s.ctrl[tcpwm_pkg::CTRL_TRAP_EN] && emergency_trap;
        mod_sig = s.aux_act ^ s.ctrl[tcpwm_pkg::CTRL_AUX_INV];
        for (int i = 0; i < NCH; i++) begin
            fld = s.mode[i*tcpwm_pkg::MODE_FIELD_W +: tcpwm_pkg::MODE_FIELD_W];
            act_p = prim_act[i] && fld[tcpwm_pkg::PIN_PRIMARY] &&
                !fld[tcpwm_pkg::MODE_CAPTURE];
            act_c = comp_act[i] && fld[tcpwm_pkg::PIN_COMPL] &&
                !fld[tcpwm_pkg::MODE_CAPTURE] &&
                (!fld[tcpwm_pkg::MODE_BURST] || mod_sig);
            next_s.pins.primary_oe[i] = !fld[tcpwm_pkg::MODE_CAPTURE];
            if (trap) begin
                next_s.pins.primary_out[i] =
                    port_latch[tcpwm_pkg::PASS_PRIMARY + i];
                next_s.pins.complementary_out[i] =
                    port_latch[tcpwm_pkg::PASS_COMPL + i];
            end else begin
                next_s.pins.primary_out[i] =
                    s.passive[tcpwm_pkg::PASS_PRIMARY + i] ^ act_p;
                next_s.pins.complementary_out[i] =
                    s.passive[tcpwm_pkg::PASS_COMPL + i] ^ act_c;
            end
        end
        if (trap) begin
            next_s.pins.aux_pwm_out = port_latch[tcpwm_pkg::PASS_AUX];
        end else begin
            next_s.pins.aux_pwm_out = s.passive[tcpwm_pkg::PASS_AUX] ^
                (s.aux_act && s.ctrl[tcpwm_pkg::CTRL_AUX_OE]);
        end

        // Read data stands one cycle only
        if (bus.rd) begin
            unique case (bus.addr)
                tcpwm_pkg::OFF_TIMER_CTRL:   rd_val = s.ctrl;
                tcpwm_pkg::OFF_MAIN_PERIOD:  rd_val = DW'(s.main_period);
                tcpwm_pkg::OFF_AUX_PERIOD:   rd_val = DW'(s.aux_period);
                tcpwm_pkg::OFF_DEAD_TIME:    rd_val = DW'(s.offset);
                tcpwm_pkg::OFF_COMPARE0:     rd_val = DW'(s.compare[0]);
                tcpwm_pkg::OFF_COMPARE1:     rd_val = DW'(s.compare[1]);
                tcpwm_pkg::OFF_COMPARE2:     rd_val = DW'(s.compare[2]);
                tcpwm_pkg::OFF_AUX_COMPARE:  rd_val = DW'(s.aux_compare);
                tcpwm_pkg::OFF_PASSIVE_CTRL: rd_val = DW'(s.passive);
                tcpwm_pkg::OFF_MODE_SELECT:  rd_val = DW'(s.mode);
                tcpwm_pkg::OFF_CAPTURE_EDGE: rd_val = DW'(s.cap_edge);
                tcpwm_pkg::OFF_MAIN_COUNT:   rd_val = DW'(s.main_count);
                tcpwm_pkg::OFF_AUX_COUNT:    rd_val = DW'(s.aux_count);
                tcpwm_pkg::OFF_STATUS:
                    rd_val = DW'({s.aux_act, comp_act, prim_act,
                                  s.main_up, trap});
                default:                     rd_val = '0;
            endcase
        end
        next_s.rdata = rd_val;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '0;
            s.ctrl <= tcpwm_pkg::RST_CTRL;
            s.main_period <= MAIN_W'(tcpwm_pkg::RST_MAIN_PERIOD);
            s.aux_period <= AUX_W'(tcpwm_pkg::RST_AUX_PERIOD);
            s.offset <= MAIN_W'(tcpwm_pkg::RST_ZERO);
            for (int i = 0; i < NCH; i++) begin
                s.compare[i] <= MAIN_W'(tcpwm_pkg::RST_COMPARE);
            end
            s.aux_compare <= AUX_W'(tcpwm_pkg::RST_AUX_COMPARE);
            s.main_up <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign pins = s.pins;

endmodule

// ===== testbench/tcpwm_unit_asserts.sv
// Purpose: Port assertions for the PWM unit
// Assumes: Control shadows rebuilt from bus writes
// Notes:   Bound to every tcpwm_unit instance
`timescale 1ns/1ns
module tcpwm_unit_asserts (
    input wire logic                          clk_sys,
    input wire logic                          reset_n,
    input wire tcpwm_pkg::tcpwm_bus_t         bus,
    input wire logic [tcpwm_pkg::DATA_W-1:0]  rdata,
    input wire logic [tcpwm_pkg::NCH-1:0]     cc_pin_in,
    input wire logic                          emergency_trap,
    input wire logic [tcpwm_pkg::LEVEL_W-1:0] port_latch,
    input wire tcpwm_pkg::tcpwm_pins_t        pins
);
    logic [15:0] ctl;
    logic [11:0] mode;
    logic [6:0]  pas;
    logic        trap_on;
    logic [6:0]  out7;
    assign trap_on = ctl[11] & emergency_trap;
    assign out7 = {pins.aux_pwm_out, pins.complementary_out, pins.primary_out};
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctl <= '0;
            mode <= '0;
            pas <= '0;
        end else if (bus.wr) begin
            if (bus.addr == tcpwm_pkg::OFF_TIMER_CTRL) ctl <= bus.wdata;
            if (bus.addr == tcpwm_pkg::OFF_MODE_SELECT) mode <= bus.wdata[11:0];
            if (bus.addr == tcpwm_pkg::OFF_PASSIVE_CTRL) pas <= bus.wdata[6:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    rdata_idle_a: assert property (
        !$past(bus.rd) |-> rdata == 16'h0000) else $error("rdata without read");
    aux_width_a: assert property (
        $past(bus.rd) && $past(bus.addr) == tcpwm_pkg::OFF_AUX_COUNT
        |-> rdata[15:10] == 6'h00) else $error("aux count too wide");
    pas_read_a: assert property (
        $past(bus.rd) && $past(bus.addr) == tcpwm_pkg::OFF_PASSIVE_CTRL
        |-> rdata == {9'h000, $past(pas)}) else $error("passive readback");
    trap_lvl_a: assert property (
        $past(trap_on) && $past(trap_on, 2) |-> out7 == $past(port_latch))
        else $error("trap level wrong");
    aux_pass_a: assert property (
        !$past(ctl[9]) && !$past(trap_on)
        |-> pins.aux_pwm_out == $past(pas[6])) else $error("aux not passive");
    oe_mode_a: assert property (
        $past(reset_n) |-> pins.primary_oe
        == ~{$past(mode[10]), $past(mode[6]), $past(mode[2])})
        else $error("oe does not follow mode");
    prim_unsel_a: assert property (
        !$past(mode[0]) && !$past(trap_on)
        |-> pins.primary_out[0] == $past(pas[0])) else $error("prim unsel");
    comp_unsel_a: assert property (
        !$past(mode[1]) && !$past(trap_on)
        |-> pins.complementary_out[0] == $past(pas[3])) else $error("comp unsel");
    cover property ($past(trap_on) && $past(trap_on, 2));
    cover property (pins.primary_oe != 3'b111);
    cover property ($past(bus.rd) && rdata != 16'h0000);
endmodule
bind tcpwm_unit tcpwm_unit_asserts u_tcpwm_unit_asserts (.clk_sys(clk_sys),
    .reset_n(reset_n), .bus(bus), .rdata(rdata), .cc_pin_in(cc_pin_in),
    .emergency_trap(emergency_trap), .port_latch(port_latch), .pins(pins));

// ===== testbench/tcpwm_bridge_model.sv
// Purpose: Bridge side model: sensor pins, trap input, trap latches
// Assumes: Calls start just after a rising edge
// Notes:   Pin wire resolved from the unit's enable and own source
`timescale 1ns/1ns
module tcpwm_bridge_model (
    input  wire logic                     clk_sys,
    input  wire tcpwm_pkg::tcpwm_pins_t   pins,
    output logic [tcpwm_pkg::NCH-1:0]     cc_pin_in,
    output logic                          emergency_trap,
    output logic [tcpwm_pkg::LEVEL_W-1:0] port_latch
);
    logic [2:0] sense;
    initial begin
        sense = 3'b000;
        emergency_trap = 1'b0;
        port_latch = 7'h00;
    end
    assign cc_pin_in = (pins.primary_oe & pins.primary_out)
                     | (~pins.primary_oe & sense);
    task automatic set_sense(input logic [2:0] v);
        @(posedge clk_sys);
        sense <= v;
    endtask
    task automatic set_trap(input logic on, input logic [6:0] lvl);
        @(posedge clk_sys);
        port_latch <= lvl;
        emergency_trap <= on;
    endtask
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench for the PWM unit
// Assumes: Bus tasks entered just after a rising edge
// Notes:   Duty measured over whole periods, phase free
`timescale 1ns/1ns
module testbench;
    logic                   clk_sys;
    logic                   reset_n;
    tcpwm_pkg::tcpwm_bus_t  bus;
    logic [15:0]            rdata;
    logic [2:0]             cc_pin_in;
    logic                   emergency_trap;
    logic [6:0]             port_latch;
    tcpwm_pkg::tcpwm_pins_t pins;
    int                     miscompares;
    int                     samples_checked;
    logic [15:0]            held;
    tcpwm_unit u_tcpwm_unit (.clk_sys(clk_sys), .reset_n(reset_n),
        .bus(bus), .rdata(rdata), .cc_pin_in(cc_pin_in),
        .emergency_trap(emergency_trap), .port_latch(port_latch), .pins(pins));
    tcpwm_bridge_model u_tcpwm_bridge_model (.clk_sys(clk_sys), .pins(pins),
        .cc_pin_in(cc_pin_in), .emergency_trap(emergency_trap),
        .port_latch(port_latch));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 q = rdata;
        @(posedge clk_sys);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] q;
        rd(a, q);
        chk(q, e);
    endtask
    // Count high cycles of one output after settling
    task automatic duty(input int sel, input int n, input int exp);
        int   cnt;
        logic b;
        cnt = 0;
        repeat (n) @(posedge clk_sys);
        repeat (n) begin
            @(posedge clk_sys);
            #1;
            case (sel)
                0: b = pins.primary_out[0];
                1: b = pins.complementary_out[0];
                2: b = pins.primary_out[1];
                default: b = pins.aux_pwm_out;
            endcase
            if (b === 1'b1) cnt++;
        end
        @(posedge clk_sys);
        chk(16'(cnt), 16'(exp));
    endtask
    task automatic test_reset();
        rdc(tcpwm_pkg::OFF_MAIN_PERIOD, 16'hffff);
        rdc(tcpwm_pkg::OFF_AUX_PERIOD, 16'h03ff);
        rdc(tcpwm_pkg::OFF_COMPARE0, 16'hffff);
        rdc(tcpwm_pkg::OFF_AUX_COMPARE, 16'h03ff);
        rdc(4'he, 16'h0000);
        wr(tcpwm_pkg::OFF_MAIN_COUNT, 16'h1234);
        rdc(tcpwm_pkg::OFF_MAIN_COUNT, 16'h0000);
        $display("test_reset done");
    endtask
    task automatic test_edge();
        wr(tcpwm_pkg::OFF_MAIN_PERIOD, 16'h0003);
        wr(tcpwm_pkg::OFF_COMPARE0, 16'h0001);
        wr(tcpwm_pkg::OFF_DEAD_TIME, 16'h0001);
        wr(tcpwm_pkg::OFF_MODE_SELECT, 16'h0013);
        for (int s = 0; s < 8; s++) begin
            wr(tcpwm_pkg::OFF_TIMER_CTRL, 16'h0008 | 16'(s));
            duty(0, 8 << s, 6 << s);
        end
        wr(tcpwm_pkg::OFF_TIMER_CTRL, 16'h0008);
        duty(1, 8, 8);
        duty(2, 8, 0);
        $display("test_edge done");
    endtask
    task automatic test_center();
        wr(tcpwm_pkg::OFF_MAIN_PERIOD, 16'h0004);
        wr(tcpwm_pkg::OFF_DEAD_TIME, 16'h0000);
        wr(tcpwm_pkg::OFF_TIMER_CTRL, 16'h0018);
        duty(0, 16, 12);
        duty(1, 16, 12);
        $display("test_center done");
    endtask
    task automatic test_aux();
        wr(tcpwm_pkg::OFF_AUX_PERIOD, 16'h0003);
        wr(tcpwm_pkg::OFF_AUX_COMPARE, 16'h0001);
        wr(tcpwm_pkg::OFF_PASSIVE_CTRL, 16'h0040);
        wr(tcpwm_pkg::OFF_TIMER_CTRL, 16'h0100);
        duty(3, 8, 8);
        wr(tcpwm_pkg::OFF_TIMER_CTRL, 16'h0300);
        duty(3, 8, 2);
        rdc(tcpwm_pkg::OFF_PASSIVE_CTRL, 16'h0040);
        $display("test_aux done");
    endtask
    task automatic test_trap();
        wr(tcpwm_pkg::OFF_TIMER_CTRL, 16'h0808);
        u_tcpwm_bridge_model.set_trap(1'b1, 7'h55);
        repeat (3) @(posedge clk_sys);
        #1 chk({9'h000, pins.aux_pwm_out, pins.complementary_out,
                pins.primary_out}, 16'h0055);
        u_tcpwm_bridge_model.set_trap(1'b0, 7'h55);
        $display("test_trap done");
    endtask
    task automatic test_capture();
        wr(tcpwm_pkg::OFF_CAPTURE_EDGE, 16'h0010);
        wr(tcpwm_pkg::OFF_MODE_SELECT, 16'h0400);
        wr(tcpwm_pkg::OFF_TIMER_CTRL, 16'h0000);
        rd(tcpwm_pkg::OFF_MAIN_COUNT, held);
        u_tcpwm_bridge_model.set_sense(3'b100);
        repeat (3) @(posedge clk_sys);
        rdc(tcpwm_pkg::OFF_COMPARE2, held);
        $display("test_capture done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #500000;
        miscompares++;
        finish_test();
    end
    initial begin
        miscompares = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        bus = '0;
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        test_reset();
        test_edge();
        test_center();
        test_aux();
        test_trap();
        test_capture();
        finish_test();
    end
endmodule
